// >>> rtl/piolc_defs.vh
// register offsets and reset values of the parallel i/o line controller
// Functional notes
// [R01] up to 32 lines; line n is bit n of every vector
// [R02] pull-up on strobe clears status bit, off strobe sets it; 1 means off
// [R03] pull-up strobes act whatever the line ownership or direction
// [R04] pull-up status resets to zero, all pull-ups on; o_pullup_en itself resets to 0 and turns on at the first edge after reset
// [R05] ownership set strobe gives line to controller, clear strobe to peripheral
// [R06] lines without peripheral ignore ownership strobes and always read 1
// [R07] ownership reset value is a per-line constant, normally 1
// [R08] select-a strobe clears choice bit, select-b sets it; 0 is a, 1 is b
// [R09] a/b choice steers only output paths; pin input reaches both peripherals
// [R10] peripheral choice resets to zero, peripheral a everywhere
// [R11] a/b strobes update the choice whatever the ownership
// [R12] software writes a or b select and ownership clear to hand over
// [R13] peripheral-owned line takes drive and level from chosen peripheral
// [R14] drive on strobe sets, drive off clears; 1 drives under controller ownership
// [R15] level set and clear strobes change the output level vector
// [R16] drive and level strobes act even while a peripheral owns the line
// [R17] direct output write changes only bits enabled in the write mask
// [R18] write mask set and clear strobes; mask resets to zero
// [R19] register writes work while the input clock is gated off
// [R20] pin read, change detection and interrupt work only with clock enabled
// [R21] input clock off after reset; software enables it before reading inputs
// [R22] single interrupt output goes to a peripheral source 2..31
// [R23] pin level vector shows every line; holds last sample with clock off
// [R24] glitch filter rejects short pulses, affects only readback and detection
// [R25] change sets pending bit, masked onto interrupt; reading pending clears all
// [R26] only bits written as 1 change a vector; unimplemented lines ignored; the masked direct level write also clears bits written as 0
`ifndef PIOLC_DEFS_VH
`define PIOLC_DEFS_VH
`define PIOLC_OWN_SET      8'h00
`define PIOLC_OWN_CLR      8'h04
`define PIOLC_OWN_STAT     8'h08
`define PIOLC_DRV_ON       8'h10
`define PIOLC_DRV_OFF      8'h14
`define PIOLC_DRV_STAT     8'h18
`define PIOLC_FLT_ON       8'h20
`define PIOLC_FLT_OFF      8'h24
`define PIOLC_FLT_STAT     8'h28
`define PIOLC_LVL_SET      8'h30
`define PIOLC_LVL_CLR      8'h34
`define PIOLC_LVL_VEC      8'h38
`define PIOLC_PIN_VEC      8'h3c
`define PIOLC_IRQ_ON       8'h40
`define PIOLC_IRQ_OFF      8'h44
`define PIOLC_IRQ_MASK     8'h48
`define PIOLC_PEND_VEC     8'h4c
`define PIOLC_MD_ON        8'h50
`define PIOLC_MD_OFF       8'h54
`define PIOLC_MD_STAT      8'h58
`define PIOLC_PU_OFF       8'h60
`define PIOLC_PU_ON        8'h64
`define PIOLC_PU_STAT      8'h68
`define PIOLC_SEL_A        8'h70
`define PIOLC_SEL_B        8'h74
`define PIOLC_CHOICE       8'h78
`define PIOLC_WM_SET       8'ha0
`define PIOLC_WM_CLR       8'ha4
`define PIOLC_WM_STAT      8'ha8
`define PIOLC_RST_ZERO     32'h0000_0000
`define PIOLC_RST_OWN      32'hffff_ffff
`define PIOLC_RST_PERIPH   32'hffff_ffff
`endif

// >>> rtl/piolc_top.v
// parallel i/o line controller with apb register access
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`include "piolc_defs.vh"

module piolc_top #(
  parameter [31:0] LINE_MASK   = `PIOLC_RST_OWN,
  parameter [31:0] PERIPH_MASK = `PIOLC_RST_PERIPH,
  parameter [31:0] OWN_RESET   = `PIOLC_RST_OWN
) (
  input  wire        i_mclk,
  input  wire        i_rstn,
  input  wire        i_in_clk_en,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [31:0] o_prdata,
  input  wire [31:0] i_pin_in,
  output reg  [31:0] o_pin_out,
  output reg  [31:0] o_pin_oe,
  output reg  [31:0] o_pullup_en,
  input  wire [31:0] i_pa_out,
  input  wire [31:0] i_pa_oe,
  input  wire [31:0] i_pb_out,
  input  wire [31:0] i_pb_oe,
  output reg  [31:0] o_periph_in,
  output reg         o_irq
);

  // [R26] set wins over clear; only implemented lines move
  // [R01] line n is bit n of every vector, LINE_MASK marks the lines built
  function [31:0] setclr;
    input [31:0] cur;
    input [31:0] set;
    input [31:0] clr;
    begin
      setclr = (cur & ~(clr & LINE_MASK)) | (set & LINE_MASK);
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  reg  [31:0] own_q;
  reg  [31:0] own_d;
  reg  [31:0] drv_q;
  reg  [31:0] drv_d;
  reg  [31:0] lvl_q;
  reg  [31:0] lvl_d;
  reg  [31:0] wmask_q;
  reg  [31:0] wmask_d;
  reg  [31:0] pu_off_q;
  reg  [31:0] pu_off_d;
  reg  [31:0] choice_q;
  reg  [31:0] choice_d;
  reg  [31:0] flt_q;
  reg  [31:0] flt_d;
  reg  [31:0] md_q;
  reg  [31:0] md_d;
  reg  [31:0] imask_q;
  reg  [31:0] imask_d;
  reg  [31:0] pend_q;
  reg  [31:0] pend_d;
  reg  [31:0] sync1_q;
  reg  [31:0] sync2_q;
  reg  [31:0] sync3_q;
  reg  [31:0] sync4_q;
  reg  [31:0] pin_q;
  reg  [31:0] pin_d;
  reg  [31:0] rd_d;
  reg         mapped_d;
  reg         err_q;

  wire        setup_rd = i_psel & ~i_penable & ~i_pwrite;
  wire        acc      = i_psel & i_penable;
  wire        wr       = acc & i_pwrite;
  wire [31:0] wd       = i_pwdata;
  wire [31:0] own_eff  = own_q | ~PERIPH_MASK;

  // zero wait states: every access completes in its first access cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & err_q;

  // configuration strobes, all on the free-running bus clock
  always @* begin
    own_d    = own_q;
    drv_d    = drv_q;
    lvl_d    = lvl_q;
    wmask_d  = wmask_q;
    pu_off_d = pu_off_q;
    choice_d = choice_q;
    flt_d    = flt_q;
    md_d     = md_q;
    imask_d  = imask_q;
    if (wr) begin
      // [R05] ownership strobes
      if (hit(i_paddr, `PIOLC_OWN_SET)) begin
        own_d = setclr(own_q, wd & PERIPH_MASK, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_OWN_CLR)) begin
        // [R06] unmuxed lines stay owned
        own_d = setclr(own_q, 32'h0000_0000, wd & PERIPH_MASK);
      // [R14] drive strobes, [R16] whatever the ownership
      end else if (hit(i_paddr, `PIOLC_DRV_ON)) begin
        drv_d = setclr(drv_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_DRV_OFF)) begin
        drv_d = setclr(drv_q, 32'h0000_0000, wd);
      end else if (hit(i_paddr, `PIOLC_FLT_ON)) begin
        flt_d = setclr(flt_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_FLT_OFF)) begin
        flt_d = setclr(flt_q, 32'h0000_0000, wd);
      // [R15] level strobes
      end else if (hit(i_paddr, `PIOLC_LVL_SET)) begin
        lvl_d = setclr(lvl_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_LVL_CLR)) begin
        lvl_d = setclr(lvl_q, 32'h0000_0000, wd);
      end else if (hit(i_paddr, `PIOLC_LVL_VEC)) begin
        // [R17] masked direct write
        lvl_d = setclr(lvl_q, wd & wmask_q, ~wd & wmask_q);
      end else if (hit(i_paddr, `PIOLC_IRQ_ON)) begin
        imask_d = setclr(imask_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_IRQ_OFF)) begin
        imask_d = setclr(imask_q, 32'h0000_0000, wd);
      end else if (hit(i_paddr, `PIOLC_MD_ON)) begin
        md_d = setclr(md_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_MD_OFF)) begin
        md_d = setclr(md_q, 32'h0000_0000, wd);
      // [R02] pull-up strobes, [R03] regardless of ownership
      end else if (hit(i_paddr, `PIOLC_PU_OFF)) begin
        pu_off_d = setclr(pu_off_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_PU_ON)) begin
        pu_off_d = setclr(pu_off_q, 32'h0000_0000, wd);
      // [R08] a/b select, [R11] regardless of ownership
      end else if (hit(i_paddr, `PIOLC_SEL_A)) begin
        choice_d = setclr(choice_q, 32'h0000_0000, wd);
      end else if (hit(i_paddr, `PIOLC_SEL_B)) begin
        choice_d = setclr(choice_q, wd, 32'h0000_0000);
      // [R18] write mask strobes
      end else if (hit(i_paddr, `PIOLC_WM_SET)) begin
        wmask_d = setclr(wmask_q, wd, 32'h0000_0000);
      end else if (hit(i_paddr, `PIOLC_WM_CLR)) begin
        wmask_d = setclr(wmask_q, 32'h0000_0000, wd);
      end
    end
  end

  // [R19] configuration never waits on the input clock enable
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      // [R07] per-line ownership reset
      own_q    <= OWN_RESET | ~PERIPH_MASK;
      drv_q    <= `PIOLC_RST_ZERO;
      lvl_q    <= `PIOLC_RST_ZERO;
      // [R18] mask reset
      wmask_q  <= `PIOLC_RST_ZERO;
      // [R04] pull-ups on
      pu_off_q <= `PIOLC_RST_ZERO;
      // [R10] peripheral a
      choice_q <= `PIOLC_RST_ZERO;
      flt_q    <= `PIOLC_RST_ZERO;
      md_q     <= `PIOLC_RST_ZERO;
      imask_q  <= `PIOLC_RST_ZERO;
    end else begin
      own_q    <= own_d;
      drv_q    <= drv_d;
      lvl_q    <= lvl_d;
      wmask_q  <= wmask_d;
      pu_off_q <= pu_off_d;
      choice_q <= choice_d;
      flt_q    <= flt_d;
      md_q     <= md_d;
      imask_q  <= imask_d;
    end
  end

  // [R24] filtered lines need one more agreeing sample
  always @* begin
    pin_d = pin_q;
    if (i_in_clk_en) begin
      pin_d = (((sync2_q ~^ sync3_q) & ~flt_q) |
               ((sync2_q ~^ sync3_q) & (sync3_q ~^ sync4_q) & flt_q)) & LINE_MASK;
      pin_d = (sync3_q & pin_d) | (pin_q & ~pin_d);
    end
  end

  // [R25] a change sets pending; a set beats the clear-on-read
  always @* begin
    pend_d = pend_q;
    if (acc & ~i_pwrite & hit(i_paddr, `PIOLC_PEND_VEC)) begin
      pend_d = `PIOLC_RST_ZERO;
    end
    // [R20] detection only with the input clock running
    if (i_in_clk_en) begin
      pend_d = pend_d | ((pin_d ^ pin_q) & LINE_MASK);
    end
  end

  // [R21] the input side is frozen until software enables its clock
  // [R23] pin vector holds its last sample while the clock is off
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q <= `PIOLC_RST_ZERO;
      sync2_q <= `PIOLC_RST_ZERO;
      sync3_q <= `PIOLC_RST_ZERO;
      sync4_q <= `PIOLC_RST_ZERO;
      pin_q   <= `PIOLC_RST_ZERO;
      pend_q  <= `PIOLC_RST_ZERO;
    end else begin
      if (i_in_clk_en) begin
        sync1_q <= i_pin_in;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
        sync4_q <= sync3_q;
      end
      pin_q  <= pin_d;
      pend_q <= pend_d;
    end
  end

  // read data is latched in the setup cycle so it comes from flops
  always @* begin
    rd_d     = `PIOLC_RST_ZERO;
    mapped_d = 1'b1;
    if (hit(i_paddr, `PIOLC_OWN_STAT)) begin
      // [R06] unmuxed lines read 1
      rd_d = own_eff & LINE_MASK;
    end else if (hit(i_paddr, `PIOLC_DRV_STAT)) begin
      rd_d = drv_q;
    end else if (hit(i_paddr, `PIOLC_FLT_STAT)) begin
      rd_d = flt_q;
    end else if (hit(i_paddr, `PIOLC_LVL_VEC)) begin
      rd_d = lvl_q;
    end else if (hit(i_paddr, `PIOLC_PIN_VEC)) begin
      // [R23] sampled level of every line
      rd_d = pin_q;
    end else if (hit(i_paddr, `PIOLC_IRQ_MASK)) begin
      rd_d = imask_q;
    end else if (hit(i_paddr, `PIOLC_PEND_VEC)) begin
      rd_d = pend_q;
    end else if (hit(i_paddr, `PIOLC_MD_STAT)) begin
      rd_d = md_q;
    end else if (hit(i_paddr, `PIOLC_PU_STAT)) begin
      rd_d = pu_off_q;
    end else if (hit(i_paddr, `PIOLC_CHOICE)) begin
      rd_d = choice_q;
    end else if (hit(i_paddr, `PIOLC_WM_STAT)) begin
      rd_d = wmask_q;
    end else if (i_pwrite && (hit(i_paddr, `PIOLC_OWN_SET) || hit(i_paddr, `PIOLC_OWN_CLR) ||
             hit(i_paddr, `PIOLC_DRV_ON) || hit(i_paddr, `PIOLC_DRV_OFF) ||
             hit(i_paddr, `PIOLC_FLT_ON) || hit(i_paddr, `PIOLC_FLT_OFF) ||
             hit(i_paddr, `PIOLC_LVL_SET) || hit(i_paddr, `PIOLC_LVL_CLR) ||
             hit(i_paddr, `PIOLC_IRQ_ON) || hit(i_paddr, `PIOLC_IRQ_OFF) ||
             hit(i_paddr, `PIOLC_MD_ON) || hit(i_paddr, `PIOLC_MD_OFF) ||
             hit(i_paddr, `PIOLC_PU_ON) || hit(i_paddr, `PIOLC_PU_OFF) ||
             hit(i_paddr, `PIOLC_SEL_A) || hit(i_paddr, `PIOLC_SEL_B) ||
             hit(i_paddr, `PIOLC_WM_SET) || hit(i_paddr, `PIOLC_WM_CLR))) begin
      rd_d = `PIOLC_RST_ZERO;
    end else begin
      // write-only strobes read back or unmapped offsets: refused with an error
      mapped_d = 1'b0;
    end
  end

  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= `PIOLC_RST_ZERO;
      err_q    <= 1'b0;
    end else if (i_psel & ~i_penable) begin
      o_prdata <= setup_rd ? rd_d : `PIOLC_RST_ZERO;
      err_q    <= ~mapped_d;
    end
  end

  // pin drive: registered so pins change one edge after the strobe
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out   <= `PIOLC_RST_ZERO;
      o_pin_oe    <= `PIOLC_RST_ZERO;
      o_pullup_en <= `PIOLC_RST_ZERO;
      o_periph_in <= `PIOLC_RST_ZERO;
      o_irq       <= 1'b0;
    end else begin
      // [R13] peripheral path by choice, [R15] controller path by level bits
      o_pin_out <= ((own_eff & lvl_q) |
                    (~own_eff & ((choice_q & i_pb_out) | (~choice_q & i_pa_out)))) & LINE_MASK;
      // open drain lines only drive while the level is low
      o_pin_oe  <= ((own_eff & drv_q) |
                    (~own_eff & ((choice_q & i_pb_oe) | (~choice_q & i_pa_oe)))) &
                   ~(md_q & o_pin_out_next(own_eff, lvl_q, choice_q)) & LINE_MASK;
      o_pullup_en <= ~pu_off_q & LINE_MASK;
      // [R09] raw pin input to both peripherals
      o_periph_in <= i_pin_in;
      // [R22] single wired-or interrupt, [R20] only with input clock
      o_irq <= i_in_clk_en & (|(pend_q & imask_q));
    end
  end

  function [31:0] o_pin_out_next;
    input [31:0] own;
    input [31:0] lvl;
    input [31:0] ch;
    begin
      o_pin_out_next = (own & lvl) | (~own & ((ch & i_pb_out) | (~ch & i_pa_out)));
    end
  endfunction

endmodule // piolc_top

// >>> test/piolc_far_side.sv
// far-side model: package pins and the two multiplexed peripherals
`timescale 1ns/10ps
module piolc_far_side #(
  parameter [31:0] PA_OUT = 32'ha5a5_a5a5,
  parameter [31:0] PA_OE  = 32'h0f0f_0f0f,
  parameter [31:0] PB_OUT = 32'h3c3c_3c3c,
  parameter [31:0] PB_OE  = 32'hf0f0_f0f0
) (
  input  wire logic        i_mclk,
  input  wire logic [31:0] i_pin_out,
  input  wire logic [31:0] i_pin_oe,
  input  wire logic [31:0] i_pullup_en,
  output logic      [31:0] o_pin_in,
  output logic      [31:0] o_pa_out,
  output logic      [31:0] o_pa_oe,
  output logic      [31:0] o_pb_out,
  output logic      [31:0] o_pb_oe
);
  logic [31:0] last_q = 32'h0;
  // distinct patterns show which peripheral reached the pin
  assign o_pa_out = PA_OUT;
  assign o_pa_oe  = PA_OE;
  assign o_pb_out = PB_OUT;
  assign o_pb_oe  = PB_OE;
  // undriven pin: pull-up gives 1, else it wanders so no stale level passes
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & (i_pullup_en | ~last_q));
  always @(posedge i_mclk) begin
    last_q <= o_pin_in;
  end
endmodule // piolc_far_side

// >>> test/piolc_props.sv
// port-level assertions for the parallel i/o line controller
`timescale 1ns/10ps
module piolc_props #(
  parameter [31:0] LINE_MASK = 32'hffff_ffff
) (
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic        i_in_clk_en,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic [31:0] i_pin_in,
  input wire logic [31:0] o_pullup_en,
  input wire logic [31:0] o_periph_in,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr(logic [7:0] a);
    i_psel && !i_penable && i_pwrite && i_paddr == a ##1 i_psel && i_penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a ##1 i_psel && i_penable;
  endsequence
  a_ready_always: assert property (o_pready)
    else $error("pready low");
  a_pullup_reset: assert property ($rose(i_rstn) |=> o_pullup_en == LINE_MASK)
    else $error("pull-ups not on after reset");
  a_pullup_on: assert property (s_wr(8'h64) |-> ##2
    (o_pullup_en & $past(i_pwdata, 2) & LINE_MASK) == ($past(i_pwdata, 2) & LINE_MASK))
    else $error("pull-up not switched on");
  a_pullup_off: assert property (s_wr(8'h60) |-> ##2
    (o_pullup_en & $past(i_pwdata, 2)) == 32'h0)
    else $error("pull-up not switched off");
  a_periph_in_copy: assert property ($past(i_rstn) |-> o_periph_in == $past(i_pin_in))
    else $error("peripheral input differs from pin");
  a_strobe_read_err: assert property (s_rd(8'h64) |-> o_pslverr && o_prdata == 32'h0)
    else $error("write-only read accepted");
  a_unmapped_err: assert property (i_psel && i_penable && i_paddr == 8'h0c |-> o_pslverr)
    else $error("unmapped access accepted");
  a_irq_needs_clk: assert property ($past(i_rstn) && !$past(i_in_clk_en) |-> !o_irq)
    else $error("irq raised with input clock off");
endmodule // piolc_props
bind piolc_top piolc_props #(.LINE_MASK(LINE_MASK)) u_props (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_in_clk_en(i_in_clk_en), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_pin_in(i_pin_in),
  .o_pullup_en(o_pullup_en), .o_periph_in(o_periph_in), .o_irq(o_irq));

// >>> test/tb_top.sv
// self-checking bench for the parallel i/o line controller
`timescale 1ns/10ps
module tb_top;
  localparam [31:0] PA_OUT = 32'ha5a5_a5a5;
  localparam [31:0] PA_OE  = 32'h0f0f_0f0f;
  localparam [31:0] PB_OUT = 32'h3c3c_3c3c;
  localparam [31:0] PB_OE  = 32'hf0f0_f0f0;
  logic        mclk, pready, pslverr, irq;
  logic        rstn = 1'b0, en = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe, pu, pa_out, pa_oe, pb_out, pb_oe, p_in;
  logic [31:0] r, m, lv, exp_q[$];
  logic [7:0]  nam_q[$];
  int          err_count = 0, tests_run = 0, cyc = 0;
  logic [7:0]  ra[5] = '{8'h08, 8'h18, 8'h68, 8'h78, 8'ha8};
  logic [31:0] rv[5] = '{32'hffff_fff0, 32'h0, 32'h0, 32'h0, 32'h0};

  piolc_top #(.PERIPH_MASK(32'h0000_ffff), .OWN_RESET(32'hffff_fff0)) uut (
    .i_mclk(mclk), .i_rstn(rstn), .i_in_clk_en(en), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pullup_en(pu), .i_pa_out(pa_out), .i_pa_oe(pa_oe),
    .i_pb_out(pb_out), .i_pb_oe(pb_oe), .o_periph_in(p_in), .o_irq(irq));
  piolc_far_side #(.PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE)) u_far (
    .i_mclk(mclk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pullup_en(pu),
    .o_pin_in(pin_in), .o_pa_out(pa_out), .o_pa_oe(pa_oe), .o_pb_out(pb_out),
    .o_pb_oe(pb_oe));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    nam_q.push_back(a);
    apb(1'b0, a, 32'h0);
  endtask
  // read results are matched in issue order
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      chk($sformatf("reg_%h", nam_q.pop_front()), prdata, exp_q.pop_front());
    end
  end

  initial begin
    r = $urandom(96842);
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    chk("own_oe", pin_oe & 32'hf, PA_OE & 32'hf);
    $display("test reset_values done");
    r = $urandom;
    wr(8'h60, r);
    rd(8'h68, r);
    wr(8'h64, r & 32'h0000_ffff);
    rd(8'h68, r & 32'hffff_0000);
    repeat (2) @(posedge mclk);
    chk("pullup", pu, ~(r & 32'hffff_0000));
    $display("test pullup done");
    // hand-over: select first, then release ownership
    wr(8'h74, 32'h0000_0f0f);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h08, 32'hffff_0000);
    rd(8'h78, 32'h0000_0f0f);
    wr(8'h00, 32'h0000_00ff);
    rd(8'h08, 32'hffff_00ff);
    repeat (2) @(posedge mclk);
    chk("periph_oe", pin_oe, (PB_OE & 32'h0f00) | (PA_OE & 32'hf000));
    chk("periph_out", pin_out & 32'hff00, (PB_OUT & 32'h0f00) | (PA_OUT & 32'hf000));
    $display("test ownership done");
    r = $urandom;
    wr(8'h10, 32'hffff_ffff);
    wr(8'h30, r);
    wr(8'h34, ~r);
    rd(8'h18, 32'hffff_ffff);
    wr(8'h00, 32'hffff_ffff);
    repeat (2) @(posedge mclk);
    chk("drive_oe", pin_oe, 32'hffff_ffff);
    chk("drive_out", pin_out, r);
    wr(8'h38, ~r);
    rd(8'h38, r);
    m = $urandom;
    wr(8'ha0, m);
    wr(8'h38, ~r);
    lv = (r & ~m) | (~r & m);
    rd(8'h38, lv);
    wr(8'ha4, m);
    rd(8'ha8, 32'h0);
    wr(8'h20, 32'h0000_000f);
    rd(8'h28, 32'h0000_000f);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h28, 32'h0);
    wr(8'h50, 32'h0000_000f);
    rd(8'h58, 32'h0000_000f);
    wr(8'h54, 32'hffff_ffff);
    rd(8'h58, 32'h0);
    rd(8'h64, 32'h0);
    rd(8'h0c, 32'h0);
    $display("test output done");
    rd(8'h3c, 32'h0);
    en <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(8'h3c, lv);
    rd(8'h4c, lv);
    rd(8'h4c, 32'h0);
    wr(8'h40, 32'h1);
    wr(lv[0] ? 8'h34 : 8'h30, 32'h1);
    lv[0] = ~lv[0];
    repeat (10) @(posedge mclk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(8'h4c, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    en <= 1'b0;
    wr(8'h34, 32'hffff_ffff);
    repeat (10) @(posedge mclk);
    rd(8'h3c, lv);
    $display("test input done");
    end_sim();
  end
endmodule // tb_top
